/* tttq_pkg.sv */
// Package for the tone, time, tag and parameter-read command block
package tttq_pkg;
  // Command opcodes
  localparam logic [7:0] TONE_GENERATE_CMD    = 8'h0D;
  localparam logic [7:0] TIME_QUERY_CMD       = 8'h0E;
  localparam logic [7:0] TAGGED_SELECT_CMD    = 8'h09;
  localparam logic [7:0] PARAM_READ_CMD       = 8'h06;
  localparam logic [7:0] ERROR_WORD_READ_CMD  = 8'h20;
  localparam logic [7:0] STOP_CMD             = 8'h00;
  localparam logic [7:0] FILLER_BYTE          = 8'hAA;
  // Error codes
  localparam logic [7:0] ERR_NONE             = 8'h00;
  localparam logic [7:0] BAD_PARAMETER_ERROR  = 8'h02;
  localparam logic [7:0] INVALID_STATE_ERROR  = 8'h01;
  // Tone byte fields
  localparam int TONE_KIND_BIT   = 0;
  localparam int TONE_FREQ_LSB   = 1;
  localparam int TONE_FREQ_W     = 5;
  localparam int TONE_KEY_W      = 4;
  localparam logic [11:0] TONE_HZ_STEP = 12'h064;
  // Time word fields
  localparam int TW_DAY_LSB  = 0;
  localparam int TW_HOUR_LSB = 3;
  localparam int TW_MIN_LSB  = 8;
  localparam int TW_SET_LSB  = 14;
  localparam logic [1:0] TW_SET_MARK   = 2'h3;
  localparam logic [1:0] TW_UNSET_MARK = 2'h0;
  localparam logic [7:0] DIR_NEWEST    = 8'h80;
  localparam logic [7:0] DIR_OLDEST    = 8'h00;
  // Bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte addresses
  localparam logic [7:0] REG_CMD_DATA   = 8'h00;
  localparam logic [7:0] REG_REPLY      = 8'h04;
  localparam logic [7:0] REG_STATUS     = 8'h08;
  localparam logic [7:0] REG_CLOCK_TIME = 8'h0C;
  localparam logic [7:0] REG_MSG_TAG    = 8'h10;
  localparam logic [7:0] REG_MSG_STAMP  = 8'h14;
  localparam logic [7:0] REG_TONE_OUT   = 8'h18;
  localparam logic [7:0] REG_PARAM_WR   = 8'h1C;
  localparam int STATUS_ERR_BIT  = 7;
  localparam int NUM_MSG_DEF     = 8;
  localparam int NUM_PARAM_DEF   = 8;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_PARAM = 4'b0010,
    ST_REPLY = 4'b0100,
    ST_TONE  = 4'b1000
  } tttq_mode_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] tag;
    logic [15:0] stamp;
  } tttq_msg_type;
endpackage

/* tttq_core.sv */
// Command interpreter for tone, time query, tagged select, parameter read
//
// Contract
// - Single tone frequency is field times 100
// - Tone runs until stop command
// - Time query returns two bytes, option selects
// - Time word bits 0-2 weekday
// - Time word bits 3-7 hour
// - Time word bits 8-13 minute
// - Bits 14-15 are 11 only when set
// - Stamp query without message gives invalid error
// - Match when tag and mask equals reference
// - Direction picks oldest, newest or skips
// - Found becomes current, result one else zero
// - Skip without current message is unpredictable
// - Parameter read takes index, returns two bytes
// - Bad index sets bad parameter error
// - Parameter read allowed in idle and reset
// - Unwritten parameter reads its default
// - Error sets flag and event request
// - Parameters default only on device reset
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module tttq_core
  import tttq_pkg::*;
#(
  parameter int NUM_MSG   = NUM_MSG_DEF,
  parameter int NUM_PARAM = NUM_PARAM_DEF
)(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Device outputs
  output logic             o_event_request_n,
  output logic             o_tone_active,
  output logic             o_tone_dual,
  output logic [11:0]      o_tone_freq_hz,
  output logic [3:0]       o_tone_key
);
  initial
  begin
    if (NUM_MSG < 2 || NUM_MSG > 128 || NUM_PARAM < 1 || NUM_PARAM > 256)
      $error("tttq_core: unsupported NUM_MSG or NUM_PARAM");
  end

  localparam int MW = $clog2(NUM_MSG);

  typedef struct packed {
    logic                awdone;
    logic [7:0]          awaddr;
    logic                wdone;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    tttq_mode_type       mode;
    logic [7:0]          opcode;
    logic [2:0]          pidx;
    logic [7:0]          pbuf0;
    logic [7:0]          pbuf1;
    logic [7:0]          pbuf2;
    logic [7:0]          pbuf3;
    logic [15:0]         result;
    logic [1:0]          rcnt;
    logic [7:0]          echo;
    logic                echo_vld;
    logic [7:0]          tone_byte;
    logic [15:0]         clock_time;
    logic                time_set;
    logic                cur_vld;
    logic [MW-1:0]       cur;
    logic [7:0]          err;
    logic                err_flag;
    tttq_msg_type [NUM_MSG-1:0]    msgs;
    logic [NUM_PARAM-1:0][15:0]    params;
  } tttq_state_type;

  tttq_state_type st_ff;
  tttq_state_type nxt_st;

  // Default parameter values; arbitrary, replace per product
  function automatic logic [15:0] param_default(input int i);
    param_default = 16'(16'h0064 * (i + 1));
  endfunction

  // Tagged search over the message table
  logic [MW:0]   sel_idx;
  logic          sel_found;
  logic [15:0]   s_ref;
  logic [15:0]   s_mask;
  logic signed [8:0] s_dir;
  always_comb
  begin
    int cnt;
    int start;
    int j;
    cnt = 0;
    start = 0;
    j = 0;
    sel_idx = '0;
    sel_found = 1'b0;
    s_ref = {st_ff.pbuf0, st_ff.pbuf1};
    s_mask = {st_ff.pbuf2, st_ff.pbuf3};
    // Direction is the byte landing now, not the previous echo
    s_dir = 9'($signed(st_ff.wdata[7:0]));
    if (s_dir == 9'sd0)
    begin
      for (int i = NUM_MSG - 1; i >= 0; i--)
        if (st_ff.msgs[i].valid &&
            ((st_ff.msgs[i].tag & s_mask) == (s_ref & s_mask)))
        begin
          sel_idx = (MW+1)'(i);
          sel_found = 1'b1;
        end
    end
    else if (st_ff.wdata[7:0] == DIR_NEWEST)
    begin
      for (int i = 0; i < NUM_MSG; i++)
        if (st_ff.msgs[i].valid &&
            ((st_ff.msgs[i].tag & s_mask) == (s_ref & s_mask)))
        begin
          sel_idx = (MW+1)'(i);
          sel_found = 1'b1;
        end
    end
    else
    begin
      // Undefined current message searches from slot 0
      start = st_ff.cur_vld ? int'(st_ff.cur) : 0;
      for (int k = 1; k < NUM_MSG; k++)
      begin
        j = (s_dir > 0) ? start + k : start - k;
        if (j >= 0 && j < NUM_MSG && !sel_found)
          if (st_ff.msgs[j].valid &&
              ((st_ff.msgs[j].tag & s_mask) == (s_ref & s_mask)))
          begin
            cnt = cnt + 1;
            if (cnt == ((s_dir > 0) ? int'(s_dir) : -int'(s_dir)))
            begin
              sel_idx = (MW+1)'(j);
              sel_found = 1'b1;
            end
          end
      end
    end
  end

  logic wr_go;
  logic [7:0] rx;
  assign wr_go = st_ff.awdone && st_ff.wdone && !st_ff.bvalid;
  assign rx = st_ff.wdata[7:0];

  always_comb
  begin
    logic [15:0] tw;
    tw = '0;
    nxt_st = st_ff;
    // Write channel, address and data in either order
    if (s_axi_awvalid && !st_ff.awdone)
    begin
      nxt_st.awdone = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.wdone)
    begin
      nxt_st.wdone = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;

    if (wr_go)
    begin
      nxt_st.awdone = 1'b0;
      nxt_st.wdone = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      unique case (st_ff.awaddr)
        REG_CMD_DATA:
        begin
          nxt_st.echo = rx;
          nxt_st.echo_vld = 1'b1;
          unique case (st_ff.mode)
            ST_IDLE:
            begin
              nxt_st.opcode = rx;
              nxt_st.pidx = '0;
              if (rx == TONE_GENERATE_CMD || rx == TIME_QUERY_CMD ||
                  rx == TAGGED_SELECT_CMD || rx == PARAM_READ_CMD)
                nxt_st.mode = ST_PARAM;
              else if (rx == ERROR_WORD_READ_CMD)
              begin
                nxt_st.result = {8'h00, st_ff.err};
                nxt_st.rcnt = 2'd2;
                nxt_st.mode = ST_REPLY;
                nxt_st.err = ERR_NONE;
                nxt_st.err_flag = 1'b0;
              end
            end
            ST_PARAM:
            begin
              nxt_st.pidx = 3'(st_ff.pidx + 3'd1);
              unique case (st_ff.pidx)
                3'd0: nxt_st.pbuf0 = rx;
                3'd1: nxt_st.pbuf1 = rx;
                3'd2: nxt_st.pbuf2 = rx;
                3'd3: nxt_st.pbuf3 = rx;
                default: ;
              endcase
              if (st_ff.opcode == TONE_GENERATE_CMD)
              begin
                nxt_st.tone_byte = rx;
                nxt_st.mode = ST_TONE;
              end
              else if (st_ff.opcode == TIME_QUERY_CMD)
              begin
                nxt_st.rcnt = 2'd2;
                nxt_st.mode = ST_REPLY;
                if (rx == 8'h00)
                  nxt_st.result = st_ff.clock_time;
                else if (!st_ff.cur_vld)
                begin
                  nxt_st.result = '0;
                  if (rx == 8'h01)
                  begin
                    nxt_st.err = INVALID_STATE_ERROR;
                    nxt_st.err_flag = 1'b1;
                  end
                end
                else
                  nxt_st.result = st_ff.msgs[st_ff.cur].stamp;
              end
              else if (st_ff.opcode == PARAM_READ_CMD)
              begin
                nxt_st.rcnt = 2'd2;
                nxt_st.mode = ST_REPLY;
                if (int'(rx) < NUM_PARAM)
                  nxt_st.result = st_ff.params[rx];
                else
                begin
                  nxt_st.result = '0;
                  nxt_st.err = BAD_PARAMETER_ERROR;
                  nxt_st.err_flag = 1'b1;
                end
              end
              else if (st_ff.pidx == 3'd4)
              begin
                nxt_st.rcnt = 2'd2;
                nxt_st.mode = ST_REPLY;
                nxt_st.result = {15'h0000, sel_found};
                if (sel_found)
                begin
                  nxt_st.cur = MW'(sel_idx);
                  nxt_st.cur_vld = 1'b1;
                end
              end
            end
            ST_REPLY:
            begin
              // Filler slots carry the result, high byte first
              nxt_st.echo = (st_ff.rcnt == 2'd2) ? st_ff.result[15:8]
                                                 : st_ff.result[7:0];
              nxt_st.rcnt = 2'(st_ff.rcnt - 2'd1);
              if (st_ff.rcnt == 2'd1)
                nxt_st.mode = ST_IDLE;
            end
            ST_TONE:
              if (rx == STOP_CMD)
                nxt_st.mode = ST_IDLE;
            default: nxt_st.mode = ST_IDLE;
          endcase
        end
        REG_CLOCK_TIME:
        begin
          tw[TW_DAY_LSB +: 3] = st_ff.wdata[TW_DAY_LSB +: 3];
          tw[TW_HOUR_LSB +: 5] = st_ff.wdata[TW_HOUR_LSB +: 5];
          tw[TW_MIN_LSB +: 6] = st_ff.wdata[TW_MIN_LSB +: 6];
          tw[TW_SET_LSB +: 2] = TW_SET_MARK;
          nxt_st.clock_time = tw;
          nxt_st.time_set = 1'b1;
        end
        REG_MSG_TAG:
        begin
          nxt_st.msgs[st_ff.wdata[16+MW-1:16]].tag = st_ff.wdata[15:0];
          nxt_st.msgs[st_ff.wdata[16+MW-1:16]].valid = st_ff.wdata[31];
          nxt_st.msgs[st_ff.wdata[16+MW-1:16]].stamp =
            st_ff.time_set ? st_ff.clock_time
                           : {TW_UNSET_MARK, st_ff.clock_time[13:0]};
        end
        REG_PARAM_WR:
          if (int'(st_ff.wdata[23:16]) < NUM_PARAM)
            nxt_st.params[st_ff.wdata[23:16]] = st_ff.wdata[15:0];
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end

    if (s_axi_arvalid && !st_ff.rvalid)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_REPLY:
        begin
          nxt_st.rdata = {23'h0, st_ff.echo_vld, st_ff.echo};
          // A byte landing in the same cycle keeps its flag
          if (!(wr_go && st_ff.awaddr == REG_CMD_DATA))
            nxt_st.echo_vld = 1'b0;
        end
        REG_STATUS:
          nxt_st.rdata = {16'h0, st_ff.err_flag, 3'h0, st_ff.mode,
                          st_ff.err};
        REG_CLOCK_TIME: nxt_st.rdata = {16'h0, st_ff.clock_time};
        REG_TONE_OUT:
          nxt_st.rdata = {15'h0, st_ff.cur_vld, 8'h0, st_ff.tone_byte};
        default:
        begin
          nxt_st.rdata = '0;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.mode <= ST_IDLE;
      for (int i = 0; i < NUM_PARAM; i++)
        st_ff.params[i] <= param_default(i);
    end
    else
      st_ff <= nxt_st;
  end

  assign s_axi_awready = !st_ff.awdone;
  assign s_axi_wready = !st_ff.wdone;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign o_event_request_n = !st_ff.err_flag;
  assign o_tone_active = (st_ff.mode == ST_TONE);
  assign o_tone_dual = st_ff.tone_byte[TONE_KIND_BIT];
  assign o_tone_key = st_ff.tone_byte[TONE_FREQ_LSB +: TONE_KEY_W];
  assign o_tone_freq_hz = o_tone_dual ? 12'h000 :
    12'(12'(st_ff.tone_byte[TONE_FREQ_LSB +: TONE_FREQ_W]) *
        TONE_HZ_STEP);

  a_tone_freq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_tone_active && !o_tone_dual |->
      o_tone_freq_hz == 12'(st_ff.tone_byte[5:1] * 12'd100))
    else $error("tone frequency wrong");
  a_tone_stop: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_tone_active && !(wr_go && st_ff.awaddr == REG_CMD_DATA) |=>
      o_tone_active)
    else $error("tone ended without stop");
  a_err_event: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(st_ff.err_flag) |-> !o_event_request_n)
    else $error("event request not raised");
  a_time_mark: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_ff.time_set |-> st_ff.clock_time[15:14] == 2'b11)
    else $error("time set mark wrong");
  a_reply_two: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(st_ff.mode == ST_REPLY) |-> st_ff.rcnt == 2'd2)
    else $error("reply not two bytes");
  a_bad_param: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_go && st_ff.awaddr == REG_CMD_DATA && st_ff.mode == ST_PARAM &&
    st_ff.opcode == PARAM_READ_CMD && int'(rx) >= NUM_PARAM |=>
      st_ff.err == BAD_PARAMETER_ERROR)
    else $error("bad index not flagged");
  a_sel_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_ff.mode == ST_PARAM && st_ff.opcode == TAGGED_SELECT_CMD &&
    st_ff.pidx == 3'd4 && wr_go && st_ff.awaddr == REG_CMD_DATA &&
    !sel_found |=> $stable(st_ff.cur) && st_ff.result == 16'h0)
    else $error("current moved on miss");
  a_stamp_err: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_ff.mode == ST_PARAM && st_ff.opcode == TIME_QUERY_CMD &&
    wr_go && st_ff.awaddr == REG_CMD_DATA && rx == 8'h01 &&
    !st_ff.cur_vld |=> st_ff.err_flag)
    else $error("missing invalid error");
endmodule

/* tttq_host.sv */
// Host model: byte-wise command master on the register bus
`timescale 1ns/1ns
module tttq_host
  import tttq_pkg::*;
(
  // Clock
  input  wire logic        i_ref_clk,
  // Write channels
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic        i_bvalid,
  // Read channels
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic        i_rvalid
);
  initial
  begin
    o_awaddr  = 8'h00;
    o_awvalid = 1'b0;
    o_wdata   = 32'h0000_0000;
    o_wvalid  = 1'b0;
    o_araddr  = 8'h00;
    o_arvalid = 1'b0;
  end

  // Block does not screen tone bytes, so only legal codes are built
  function automatic logic [7:0] tone_single(input logic [4:0] f);
    return {2'b00, f, 1'b0};
  endfunction

  function automatic logic [7:0] tone_dual(input logic [3:0] k);
    return {3'b000, k, 1'b1};
  endfunction

  function automatic logic [39:0] sel_bytes(input logic [15:0] r,
                                            input logic [15:0] m,
                                            input logic [7:0]  d);
    return {r, m, d};
  endfunction

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    o_awaddr  <= a;
    o_wdata   <= d;
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge i_ref_clk);
      if (o_awvalid && i_awready)
      begin
        aw_done = 1'b1;
        o_awvalid <= 1'b0;
      end
      if (o_wvalid && i_wready)
      begin
        w_done = 1'b1;
        o_wvalid <= 1'b0;
      end
    end
    do @(posedge i_ref_clk); while (!i_bvalid);
  endtask

  task automatic rd(input logic [7:0] a);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    do @(posedge i_ref_clk); while (!i_arready);
    o_arvalid <= 1'b0;
    do @(posedge i_ref_clk); while (!i_rvalid);
  endtask
endmodule

/* tb_tttq_core.sv */
// Self-checking bench for the tone, time, tag and parameter-read block
`timescale 1ns/1ns
module tb_tttq_core;
  import tttq_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } tttq_note_type;

  logic        i_ref_clk;
  logic        i_rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        o_event_request_n;
  logic        o_tone_active;
  logic        o_tone_dual;
  logic [11:0] o_tone_freq_hz;
  logic [3:0]  o_tone_key;
  int            mismatches;
  int            n_tests;
  logic [31:0]   seed;
  logic [15:0]   v;
  tttq_note_type q[$];

  tttq_core #(.NUM_MSG(8), .NUM_PARAM(8)) u_tttq_core (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .o_event_request_n(o_event_request_n), .o_tone_active(o_tone_active),
    .o_tone_dual(o_tone_dual), .o_tone_freq_hz(o_tone_freq_hz),
    .o_tone_key(o_tone_key));

  tttq_host u_tttq_host (
    .i_ref_clk(i_ref_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wvalid(wvalid),
    .i_wready(wready), .i_bvalid(bvalid), .o_araddr(araddr),
    .o_arvalid(arvalid), .i_arready(arready), .i_rvalid(rvalid));

  always #25 i_ref_clk = ~i_ref_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] st(input int i);
    return {2'b11, 6'(10 + i), 5'(i), 3'(i + 1)};
  endfunction

  task automatic fail(input string m);
    mismatches++;
    $display("ERROR at %0t: %s", $time, m);
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
      fail($sformatf("port value %h, expected %h", got, exp));
  endtask

  // Read result is judged by the watcher when it appears
  always @(posedge i_ref_clk)
  begin
    if (bvalid === 1'b1)
    begin
      n_tests++;
      if (bresp !== RESP_OKAY)
        fail("write response not okay");
    end
    if (rvalid === 1'b1)
    begin
      n_tests++;
      if (q.size() == 0)
        fail("read data with no note");
      else if (((rdata & q[0].mask) !== q[0].data) || (rresp !== q[0].resp))
        fail($sformatf("read %h, expected %h", rdata, q[0].data));
      if (q.size() != 0)
        void'(q.pop_front());
    end
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] r);
    q.push_back('{e & m, m, r});
    u_tttq_host.rd(a);
  endtask

  task automatic xfer(input logic [7:0] b, input logic [7:0] e,
                      input logic [7:0] m);
    u_tttq_host.wr(REG_CMD_DATA, {24'h0, b});
    rd(REG_REPLY, {23'h0, 1'b1, e}, {23'h0, 1'b1, m}, RESP_OKAY);
  endtask

  task automatic send(input logic [7:0] op, input logic [39:0] pv,
                      input int np, input logic [15:0] res,
                      input logic [15:0] rm);
    xfer(op, op, 8'hFF);
    for (int i = 0; i < np; i++)
      xfer(pv[8*(np-1-i) +: 8], pv[8*(np-1-i) +: 8], 8'hFF);
    for (int i = 0; i < 2; i++)
      xfer(FILLER_BYTE, res[8*(1-i) +: 8], rm[8*(1-i) +: 8]);
  endtask

  task automatic perr(input logic [7:0] code);
    rd(REG_STATUS, {16'h0, 1'b1, 7'h0, code}, 32'h0000_80FF, RESP_OKAY);
    chk({15'h0, o_event_request_n}, 16'h0000);
    send(ERROR_WORD_READ_CMD, '0, 0, {8'h00, code}, 16'hFFFF);
    chk({15'h0, o_event_request_n}, 16'h0001);
  endtask

  task automatic step(input logic [15:0] r, input logic [15:0] m,
                      input logic [7:0] d, input logic f, input int s);
    send(TAGGED_SELECT_CMD, u_tttq_host.sel_bytes(r, m, d), 5,
         {15'h0, f}, 16'hFFFF);
    send(TIME_QUERY_CMD, 40'(s % 2 + 1), 1, st(s), 16'hFFFF);
  endtask

  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
  endtask

  initial
  begin
    #(60000 * 50);
    fail("watchdog expired");
    conclude();
  end

  initial
  begin
    i_ref_clk = 1'b0;
    i_rst = 1'b1;
    mismatches = 0;
    n_tests = 0;
    seed = 32'he0a49ceb;
    do_reset();
    chk({15'h0, o_event_request_n}, 16'h0001);
    rd(REG_STATUS, 32'h0000_0100, 32'h0000_8F00, RESP_OKAY);
    send(TIME_QUERY_CMD, 40'h0, 1, 16'h0000, 16'hC000);
    send(TIME_QUERY_CMD, 40'h1, 1, 16'h0000, 16'h0000);
    perr(INVALID_STATE_ERROR);
    for (int i = 0; i < 8; i++)
      send(PARAM_READ_CMD, 40'(i), 1, 16'(100 * (i + 1)), 16'hFFFF);
    send(PARAM_READ_CMD, 40'h8, 1, 16'h0000, 16'h0000);
    perr(BAD_PARAMETER_ERROR);
    v = 16'(rnd());
    u_tttq_host.wr(REG_PARAM_WR, {8'h00, 8'h02, v});
    send(PARAM_READ_CMD, 40'h2, 1, v, 16'hFFFF);
    do_reset();
    send(PARAM_READ_CMD, 40'h2, 1, 16'd300, 16'hFFFF);
    for (int i = 0; i < 4; i++)
    begin
      v = {2'b00, 6'(rnd() % 60), 5'(rnd() % 24), 3'(rnd() % 7 + 1)};
      u_tttq_host.wr(REG_CLOCK_TIME, {16'h0, v});
      send(TIME_QUERY_CMD, 40'h0, 1, {2'b11, v[13:0]}, 16'hFFFF);
      rd(REG_CLOCK_TIME, {16'h0, 2'b11, v[13:0]}, 32'hFFFF, RESP_OKAY);
    end
    for (int i = 0; i < 4; i++)
    begin
      u_tttq_host.wr(REG_CLOCK_TIME, {16'h0, st(i)});
      u_tttq_host.wr(REG_MSG_TAG, {1'b1, 15'(i), 16'h1230 + 16'(i)});
    end
    // Select first, then skip relative to it
    step(16'hFFF1, 16'h0001, DIR_OLDEST, 1'b1, 1);
    step(16'h0001, 16'h0001, 8'h01, 1'b1, 3);
    step(16'h0001, 16'h0001, 8'h01, 1'b0, 3);
    step(16'h0001, 16'h0001, DIR_NEWEST, 1'b1, 3);
    step(16'h0001, 16'h0001, 8'hFF, 1'b1, 1);
    step(16'h0000, 16'hFFFF, DIR_OLDEST, 1'b0, 1);
    step(16'h0000, 16'h0001, DIR_NEWEST, 1'b1, 2);
    rd(REG_TONE_OUT, 32'h0001_0000, 32'h0001_0000, RESP_OKAY);
    for (int i = 0; i < 14; i++)
    begin
      v = (i < 10) ? 16'(i) : 16'((i == 10) ? 3 : (i == 11) ? 30 :
          rnd() % 28 + 3);
      send(TONE_GENERATE_CMD, (i < 10) ? u_tttq_host.tone_dual(v[3:0]) :
           u_tttq_host.tone_single(v[4:0]), 1, 16'h0, 16'h0);
      chk({15'h0, o_tone_active}, 16'h0001);
      chk({15'h0, o_tone_dual}, (i < 10) ? 16'h0001 : 16'h0000);
      if (i < 10)
        chk({12'h0, o_tone_key}, v);
      else
        chk({4'h0, o_tone_freq_hz}, 16'(v * 100));
      rd(REG_STATUS, 32'h0000_0800, 32'h0000_0F00, RESP_OKAY);
      send(STOP_CMD, '0, 0, 16'h0, 16'h0);
      chk({15'h0, o_tone_active}, 16'h0000);
    end
    rd(8'h40, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
    conclude();
  end
endmodule
